// ---- rtl/accessory_switch_status_regs.sv ----
// Button event, manual routing and detection status registers.
// Assumes a same-clock register port from the serial-bus slave, button
// events from the ADC decoder on this clock, and async analog status levels.

// Functional notes
// - Call/end key sets bit 0, keys one to seven set bits 1-7; read clears.
// - Keys eight to twelve set high register bits 0-4; read clears.
// - Button error sets high register bit 5; read clears.
// - Unknown key sets high bit 6; read clears; bit 7 reads zero.
// - Manual bus-power field: 00 open, 01 transistor on, 10 to microphone.
// - Other bus-power codes open all its switches; field resets to 00.
// - Manual positive field: open, USB, speakers or UART pairs.
// - Positive codes 100 to 111 open all connector-pair switches.
// - Negative field is read-only and mirrors the positive field.
// - Fixture pin driven low when bit 2 is 0, released when 1.
// - Boot pin follows bit 3 as low or high level.
// - Charge-set pin released when bit 4 is 0, driven low when 1.
// - Status bit 0 shows conversion complete.
// - Status bit 1 shows bus power above reset threshold.
// - Status bit 2 floating id line; bit 3 id grounded, resets 0.
// - Status bit 4 supply identification done, resets to 1.
// - Status bit 5 id resistance detection done, resets to 1.
// - Status bit 6 actual power transistor state; bit 7 reads 0.
module accessory_switch_status_regs
    import switch_regs_pkg::*;
(
    input wire logic sys_clk,
    input wire logic reset_n,
    // Internal register port
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    output logic reg_rvalid,
    // Button events from the key decoder
    input wire logic btn_press,
    input wire logic [3:0] btn_code,
    input wire logic btn_error,
    input wire logic btn_unknown,
    // Route select and automatic settings
    input wire logic manual_sel,
    input wire logic [1:0] auto_bus_route,
    input wire logic [2:0] auto_pos_route,
    input wire logic auto_jig_hiz,
    input wire logic auto_boot_high,
    input wire logic auto_charge_set_pin_low,
    // Analog status levels
    input wire logic adc_done,
    input wire logic bus_power_present,
    input wire logic id_open_flag,
    input wire logic id_grounded,
    input wire logic supply_ident_done,
    input wire logic id_ident_done,
    input wire logic power_switch_state,
    // Switch controls
    output logic fet_on_en,
    output logic bus_to_mic_en,
    output logic usb_pair_en,
    output logic speaker_pair_en,
    output logic uart_pair_en,
    // Pins
    output logic jig_out,
    output logic jig_oe_n,
    output logic boot_level_sel,
    output logic charge_set_out,
    output logic charge_set_oe_n
);

    // ========================================
    // Storage
    logic [7:0] btn_low_r;
    logic [7:0] btn_high_r;
    logic [4:0] route_r;
    logic [2:0] pin_r;
    logic [7:0] rdata_r;
    logic rvalid_r;
    logic fet_on_r;
    logic mic_r;
    logic usb_r;
    logic right_speaker;
    logic uart_r;
    logic jig_hiz_r;
    logic boot_r;
    logic charge_set_pin_low_r;
    logic [STATUS_W-1:0] status_sync;

    // ========================================
    // Status synchroniser
    sync3 #(
        .W(STATUS_W),
        .RST(STATUS_RESET)
    ) u_status_sync (
        .sys_clk(sys_clk),
        .reset_n(reset_n),
        .async_in({power_switch_state, id_ident_done, supply_ident_done,
                   id_grounded, id_open_flag, bus_power_present, adc_done}),
        .level_out(status_sync)
    );

    // ========================================
    // Address decode
    wire sel_low = reg_addr == OFS_BTN_LOW;
    wire sel_high = reg_addr == OFS_BTN_HIGH;
    wire sel_route = reg_addr == OFS_LINE_ROUTE;
    wire sel_pin = reg_addr == OFS_PIN_OUT;
    wire sel_status = reg_addr == OFS_STATUS;
    wire rd_low = reg_rd && sel_low;
    wire rd_high = reg_rd && sel_high;
    wire wr_route = reg_wr && sel_route;
    wire wr_pin = reg_wr && sel_pin;

    // ========================================
    // Button event capture
    wire key_valid = btn_press && (btn_code <= KEY_CODE_MAX);
    wire [NUM_KEYS-1:0] key_onehot = key_valid ?
        (13'h0001 << btn_code) : 13'h0000;
    // Out-of-range codes count as an unknown key
    wire unk_set = btn_unknown || (btn_press && !key_valid);
    wire [7:0] low_set = key_onehot[7:0];
    wire [7:0] high_set = {1'b0, unk_set, btn_error,
                           key_onehot[NUM_KEYS-1:8]};
    // Read samples and clears in one cycle; same-cycle sets win
    wire [7:0] btn_low_nxt = (rd_low ? BTN_RESET : btn_low_r) |
        low_set;
    wire [7:0] btn_high_nxt = ((rd_high ? BTN_RESET : btn_high_r) |
        high_set) & HIGH_VALID_MASK;

    // ========================================
    // Register writes; only writable fields are kept
    wire [4:0] route_nxt = wr_route ?
        reg_wdata[POS_ROUTE_MSB:BUS_ROUTE_LSB] : route_r;
    wire [2:0] pin_nxt = wr_pin ?
        reg_wdata[PIN_CHARGE_SET_PIN_BIT:PIN_JIG_BIT] : pin_r;

    wire [1:0] man_bus = route_r[BUS_ROUTE_MSB:BUS_ROUTE_LSB];
    wire [2:0] man_pos = route_r[POS_ROUTE_MSB:POS_ROUTE_LSB];

    // ========================================
    // Read mux
    wire [7:0] route_view = {man_pos, route_r};
    wire [7:0] pin_view = {3'h0, pin_r, 2'h0};
    wire [7:0] status_view = {1'b0, status_sync};
    wire [7:0] rd_mux = sel_low ? btn_low_r :
                        sel_high ? btn_high_r :
                        sel_route ? route_view :
                        sel_pin ? pin_view :
                        sel_status ? status_view : 8'h00;

    // ========================================
    // Routing decode; manual settings apply while the select is low
    wire [1:0] bus_code = manual_sel ? auto_bus_route : man_bus;
    wire [2:0] pos_code = manual_sel ? auto_pos_route : man_pos;
    wire fet_nxt = bus_code == BUS_FET_ON;
    wire mic_nxt = bus_code == BUS_TO_MIC;
    wire usb_nxt = pos_code == POS_USB;
    wire spk_nxt = pos_code == POS_AUDIO;
    wire uart_nxt = pos_code == POS_UART;
    wire jig_nxt = manual_sel ? auto_jig_hiz : pin_r[0];
    wire boot_nxt = manual_sel ? auto_boot_high : pin_r[1];
    wire charge_set_pin_nxt = manual_sel ? auto_charge_set_pin_low : pin_r[2];

    // ========================================
    // Flops
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            btn_low_r <= BTN_RESET;
            btn_high_r <= BTN_RESET;
            route_r <= ROUTE_RESET;
            pin_r <= PIN_RESET;
        end else begin
            btn_low_r <= btn_low_nxt;
            btn_high_r <= btn_high_nxt;
            route_r <= route_nxt;
            pin_r <= pin_nxt;
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            rdata_r <= 8'h00;
            rvalid_r <= 1'b0;
        end else begin
            rvalid_r <= reg_rd;
            if (reg_rd) begin
                rdata_r <= rd_mux;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            fet_on_r <= 1'b0;
            mic_r <= 1'b0;
            usb_r <= 1'b0;
            right_speaker <= 1'b0;
            uart_r <= 1'b0;
            jig_hiz_r <= 1'b0;
            boot_r <= 1'b0;
            charge_set_pin_low_r <= 1'b0;
        end else begin
            fet_on_r <= fet_nxt;
            mic_r <= mic_nxt;
            usb_r <= usb_nxt;
            right_speaker <= spk_nxt;
            uart_r <= uart_nxt;
            jig_hiz_r <= jig_nxt;
            boot_r <= boot_nxt;
            charge_set_pin_low_r <= charge_set_pin_nxt;
        end
    end

    // ========================================
    // Outputs; open-drain pins only ever pull low
    assign reg_rdata = rdata_r;
    assign reg_rvalid = rvalid_r;
    assign fet_on_en = fet_on_r;
    assign bus_to_mic_en = mic_r;
    assign usb_pair_en = usb_r;
    assign speaker_pair_en = right_speaker;
    assign uart_pair_en = uart_r;
    assign jig_out = 1'b0;
    assign jig_oe_n = jig_hiz_r;
    assign boot_level_sel = boot_r;
    assign charge_set_out = 1'b0;
    assign charge_set_oe_n = !charge_set_pin_low_r;

    // ========================================
    // Assertions
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!reset_n);

    a_key_sets_low: assert property (
        btn_press && btn_code == 4'h3 |=> btn_low_r[3])
        else $error("key three did not set its flag");

    a_key_sets_high: assert property (
        btn_press && btn_code == 4'hc |=> btn_high_r[4])
        else $error("key twelve did not set its flag");

    a_err_sets: assert property (
        btn_error |=> btn_high_r[HIGH_ERR_BIT])
        else $error("button error flag not set");

    a_high_reserved: assert property (
        reg_rvalid && $past(sel_high) |-> !reg_rdata[7])
        else $error("reserved button bit read as one");

    a_read_clears: assert property (
        rd_low && !btn_press |=> btn_low_r == BTN_RESET)
        else $error("button flags not cleared by read");

    a_set_survives: assert property (
        rd_low && btn_press && btn_code == 4'h0
        |=> btn_low_r[0] ##1 (reg_rvalid || btn_low_r[0]))
        else $error("flag lost during clearing read");

    a_bus_open: assert property (
        !manual_sel && man_bus == 2'h3
        |=> !fet_on_en && !bus_to_mic_en)
        else $error("bus-power switch closed on open code");

    a_fet_route: assert property (
        !manual_sel && man_bus == BUS_FET_ON |=> fet_on_en && !bus_to_mic_en)
        else $error("transistor not on for its code");

    a_pos_open: assert property (
        !manual_sel && man_pos[2]
        |=> !usb_pair_en && !speaker_pair_en && !uart_pair_en)
        else $error("pair switch closed on open code");

    a_neg_mirror: assert property (
        reg_rd && sel_route |=> reg_rvalid && reg_rdata[7:5] == reg_rdata[4:2])
        else $error("negative field differs from positive field");

    a_status_fixed: assert property (
        reg_wr && sel_status |=> $stable(route_r) && $stable(pin_r))
        else $error("status write disturbed other registers");

    a_boot_follow: assert property (
        !manual_sel && wr_pin |=> ##1 boot_level_sel == $past(reg_wdata[3], 2))
        else $error("boot pin does not follow written bit");

    a_charge_set_pin_pin: assert property (
        !manual_sel && pin_r[2] && $stable(pin_r) |=> !charge_set_oe_n)
        else $error("charge-set pin not driven low");

    c_key_read: cover property (btn_press ##[1:20] rd_low);
    c_usb_route: cover property (wr_route ##2 usb_pair_en);
    c_set_on_read: cover property (rd_high && btn_error);
endmodule

// ---- rtl/switch_regs_pkg.sv ----
// Constants shared by the accessory switch register bank.
// Assumes an 8-bit internal register port driven by the serial-bus slave.
package switch_regs_pkg;

    // ========================================
    // Register offsets on the internal port
    localparam logic [7:0] OFS_BTN_LOW = 8'h00;
    localparam logic [7:0] OFS_BTN_HIGH = 8'h01;
    localparam logic [7:0] OFS_LINE_ROUTE = 8'h02;
    localparam logic [7:0] OFS_PIN_OUT = 8'h03;
    localparam logic [7:0] OFS_STATUS = 8'h04;

    // ========================================
    // Field layouts
    localparam int BUS_ROUTE_LSB = 0;
    localparam int BUS_ROUTE_MSB = 1;
    localparam int POS_ROUTE_LSB = 2;
    localparam int POS_ROUTE_MSB = 4;
    localparam int NEG_ROUTE_LSB = 5;
    localparam int NEG_ROUTE_MSB = 7;
    localparam int PIN_JIG_BIT = 2;
    localparam int PIN_BOOT_BIT = 3;
    localparam int PIN_CHARGE_SET_PIN_BIT = 4;
    localparam int HIGH_ERR_BIT = 5;
    localparam int HIGH_UNK_BIT = 6;
    localparam int NUM_KEYS = 13;
    localparam int STATUS_W = 7;

    // ========================================
    // Encodings
    localparam logic [1:0] BUS_OPEN = 2'h0;
    localparam logic [1:0] BUS_FET_ON = 2'h1;
    localparam logic [1:0] BUS_TO_MIC = 2'h2;
    localparam logic [2:0] POS_OPEN = 3'h0;
    localparam logic [2:0] POS_USB = 3'h1;
    localparam logic [2:0] POS_AUDIO = 3'h2;
    localparam logic [2:0] POS_UART = 3'h3;
    localparam logic [3:0] KEY_CODE_MAX = 4'hc;

    // ========================================
    // Reset values
    localparam logic [7:0] BTN_RESET = 8'h00;
    localparam logic [4:0] ROUTE_RESET = 5'h00;
    localparam logic [2:0] PIN_RESET = 3'h0;
    // Bits 4 and 5 reset to one, bit 3 to zero; the rest reset to zero
    localparam logic [6:0] STATUS_RESET = 7'h30;
    localparam logic [7:0] HIGH_VALID_MASK = 8'h7f;

endpackage

// ---- rtl/sync3.sv ----
// Three-stage synchroniser with agreement filter for a vector of levels.
// Assumes inputs are asynchronous levels from analog detectors.
module sync3 #(
    parameter int W = 1,
    parameter logic [W-1:0] RST = '0
) (
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] level_out
);
    logic [W-1:0] meta_r;
    logic [W-1:0] s2_r;
    logic [W-1:0] s3_r;
    logic [W-1:0] level_r;
    logic [W-1:0] level_nxt;

    // A bit changes only once stages two and three agree
    assign level_nxt = (s2_r & s3_r) | (level_r & (s2_r | s3_r));
    assign level_out = level_r;

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            meta_r <= RST;
            s2_r <= RST;
            s3_r <= RST;
            level_r <= RST;
        end else begin
            meta_r <= async_in;
            s2_r <= meta_r;
            s3_r <= s2_r;
            level_r <= level_nxt;
        end
    end
endmodule

// ---- verif/host_port_model.sv ----
// Host side of the register port: single-byte writes and reads.
// Assumes the bench calls wr and rd by hierarchical name, one at a time.
module host_port_model (
    input wire logic sys_clk,
    output logic [7:0] reg_addr,
    output logic reg_wr,
    output logic reg_rd,
    output logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata,
    input wire logic reg_rvalid
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        reg_addr = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_wdata = 8'h00;
    end

    // ========================================
    // Bus cycles
    // Address and data flip once the strobe drops, so stale values
    // cannot pass for a held request.
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
        reg_addr <= ~a;
        reg_wdata <= ~d;
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] d,
                      output bit ok);
        int n;
        @(posedge sys_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        reg_addr <= ~a;
        #1;
        n = 0;
        while (reg_rvalid !== 1'b1 && n < 4) begin
            @(posedge sys_clk);
            #1;
            n++;
        end
        ok = (reg_rvalid === 1'b1);
        d = reg_rdata;
    endtask
endmodule

// ---- verif/tb.sv ----
// Self-checking bench for the accessory switch register bank.
// Assumes host_port_model drives the register port; bench drives the rest.
module tb
    import switch_regs_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic sys_clk, reset_n, reg_wr, reg_rd, reg_rvalid;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, d;
    logic btn_press, btn_error, btn_unknown, manual_sel;
    logic [3:0] btn_code, c1, c2;
    logic [1:0] auto_bus_route;
    logic [2:0] auto_pos_route;
    logic auto_jig_hiz, auto_boot_high, auto_charge_set_pin_low, e, u;
    logic [6:0] stat;
    logic [4:0] sw;
    logic jig_out, jig_oe_n, boot_level_sel, charge_set_out, charge_set_oe_n;
    logic [15:0] eb;
    logic [7:0] w, p;
    bit ok;
    int fails, n_checks, seed;

    host_port_model i_host (.sys_clk(sys_clk), .reg_addr(reg_addr),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid));

    accessory_switch_status_regs i_dut (.sys_clk(sys_clk),
        .reset_n(reset_n), .reg_addr(reg_addr), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .reg_rvalid(reg_rvalid), .btn_press(btn_press),
        .btn_code(btn_code), .btn_error(btn_error),
        .btn_unknown(btn_unknown), .manual_sel(manual_sel),
        .auto_bus_route(auto_bus_route), .auto_pos_route(auto_pos_route),
        .auto_jig_hiz(auto_jig_hiz), .auto_boot_high(auto_boot_high),
        .auto_charge_set_pin_low(auto_charge_set_pin_low), .adc_done(stat[0]),
        .bus_power_present(stat[1]), .id_open_flag(stat[2]),
        .id_grounded(stat[3]), .supply_ident_done(stat[4]),
        .id_ident_done(stat[5]), .power_switch_state(stat[6]),
        .fet_on_en(sw[4]), .bus_to_mic_en(sw[3]), .usb_pair_en(sw[2]),
        .speaker_pair_en(sw[1]), .uart_pair_en(sw[0]), .jig_out(jig_out),
        .jig_oe_n(jig_oe_n), .boot_level_sel(boot_level_sel),
        .charge_set_out(charge_set_out), .charge_set_oe_n(charge_set_oe_n));

    initial begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end

    // ========================================
    // Expectations and checks
    function automatic logic [15:0] exp_outs(input logic [1:0] b,
        input logic [2:0] r, input logic jg, input logic bt, input logic is);
        exp_outs = {6'h00, b == 2'b01, b == 2'b10, r == 3'b001,
                    r == 3'b010, r == 3'b011, jg, bt, ~is, 2'b00};
    endfunction

    function automatic logic [15:0] exp_btn(input logic [3:0] c);
        exp_btn = (c > 4'hc) ? 16'h4000 : 16'h0001 << c;
    endfunction

    task automatic chk(input string nm, input logic [15:0] ex,
                       input logic [15:0] g);
        n_checks++;
        if (g !== ex) begin
            fails++;
            $display("BAD %s expected %h seen %h", nm, ex, g);
        end
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] ex);
        i_host.rd(a, d, ok);
        chk("rvalid", 16'h0001, {15'h0000, ok});
        chk($sformatf("reg %h", a), {8'h00, ex}, {8'h00, d});
    endtask

    task automatic outs_chk(input logic [15:0] ex);
        chk("outs", ex, {6'h00, sw, jig_oe_n, boot_level_sel,
            charge_set_oe_n, jig_out, charge_set_out});
    endtask

    task automatic press(input logic [3:0] c, input logic er,
                         input logic un);
        @(posedge sys_clk);
        btn_press <= 1'b1;
        btn_code <= c;
        btn_error <= er;
        btn_unknown <= un;
        @(posedge sys_clk);
        btn_press <= 1'b0;
        btn_error <= 1'b0;
        btn_unknown <= 1'b0;
    endtask

    task automatic wrap_up;
        if (fails == 0 && n_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge sys_clk);
        fails++;
        wrap_up();
    end

    // ========================================
    // Main sequence
    initial begin
        seed = 32'hd52e6733;
        reset_n <= 1'b0;
        {btn_press, btn_error, btn_unknown, manual_sel} <= 4'h0;
        btn_code <= 4'h0;
        {auto_bus_route, auto_pos_route} <= 5'h00;
        {auto_jig_hiz, auto_boot_high, auto_charge_set_pin_low} <= 3'h0;
        stat <= 7'h00;
        repeat (20) @(posedge sys_clk);
        reset_n <= 1'b1;
        repeat (2) @(posedge sys_clk);
        outs_chk(exp_outs(2'b00, 3'b000, 1'b0, 1'b0, 1'b0));
        for (int a = 0; a < 4; a++) begin
            rd_chk(a[7:0], 8'h00);
        end
        // Keys, error and unknown, two events gathered per read
        for (int i = 0; i < 40; i++) begin
            c1 = (i < 16) ? i[3:0] : 4'($random(seed));
            c2 = 4'($random(seed));
            {e, u} = 2'($random(seed));
            press(c1, e, 1'b0);
            press(c2, 1'b0, u);
            i_host.wr(OFS_BTN_HIGH, 8'hff);
            eb = exp_btn(c1) | exp_btn(c2) | {1'b0, u, e, 13'h0000};
            rd_chk(OFS_BTN_LOW, eb[7:0]);
            rd_chk(OFS_BTN_HIGH, eb[15:8]);
        end
        // Event landing in the cycle of the clearing read
        fork
            i_host.rd(OFS_BTN_LOW, d, ok);
            press(4'h2, 1'b0, 1'b0);
        join
        chk("race read", 16'h0000, {8'h00, d});
        rd_chk(OFS_BTN_LOW, 8'h04);
        // Every route code, random pin settings and reserved bits
        for (int v = 0; v < 32; v++) begin
            w = {3'($random(seed)), v[4:0]};
            p = 8'($random(seed));
            i_host.wr(OFS_LINE_ROUTE, w);
            i_host.wr(OFS_PIN_OUT, p);
            rd_chk(OFS_LINE_ROUTE, {w[4:2], w[4:0]});
            rd_chk(OFS_PIN_OUT, p & 8'h1c);
            outs_chk(exp_outs(w[1:0], w[4:2], p[2], p[3], p[4]));
        end
        // Override select hands the pins to the automatic settings
        for (int i = 0; i < 8; i++) begin
            {auto_bus_route, auto_pos_route} <= 5'($random(seed));
            {auto_jig_hiz, auto_boot_high, auto_charge_set_pin_low} <= i[2:0];
            manual_sel <= 1'b1;
            repeat (3) @(posedge sys_clk);
            #1;
            outs_chk(exp_outs(auto_bus_route, auto_pos_route, auto_jig_hiz,
                auto_boot_high, auto_charge_set_pin_low));
        end
        manual_sel <= 1'b0;
        // Status levels, repeated reads and ignored writes
        for (int i = 0; i < 16; i++) begin
            stat <= 7'($random(seed));
            i_host.wr(OFS_STATUS, 8'hff);
            repeat (8) @(posedge sys_clk);
            rd_chk(OFS_STATUS, {1'b0, stat});
            rd_chk(OFS_STATUS, {1'b0, stat});
        end
        i_host.wr(8'h05, 8'h5a);
        rd_chk(8'h05, 8'h00);
        // Second reset in mid-run
        i_host.wr(OFS_LINE_ROUTE, 8'h0d);
        reset_n <= 1'b0;
        repeat (3) @(posedge sys_clk);
        reset_n <= 1'b1;
        rd_chk(OFS_STATUS, {1'b0, STATUS_RESET});
        rd_chk(OFS_LINE_ROUTE, 8'h00);
        wrap_up();
    end
endmodule
